// file: hw/fpwp_key_seq.sv
// Two-word unlock key sequence detector
`timescale 1ns/100ps
module fpwp_key_seq
	import fpwp_pkg::*;
#(
	parameter logic [31:0] KEY_FIRST  = fpwp_pkg::FPWP_KEY_FIRST,
	parameter logic [31:0] KEY_SECOND = fpwp_pkg::FPWP_KEY_SECOND
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        key_wr,
	input  wire logic [31:0] key_data,
	input  wire logic        other_wr,
	output logic             armed
);
	fpwp_key_state_type state;

	// Any other write in between breaks the sequence; a protect write consumes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= FPWP_KEY_IDLE;
		end else if (key_wr) begin
			if (key_data == KEY_FIRST) begin
				state <= FPWP_KEY_HALF;
			end else if (key_data == KEY_SECOND && state == FPWP_KEY_HALF) begin
				state <= FPWP_KEY_ARMED;
			end else begin
				state <= FPWP_KEY_IDLE;
			end
		end else if (other_wr) begin
			state <= FPWP_KEY_IDLE;
		end
	end

	assign armed = (state == FPWP_KEY_ARMED);
endmodule

// file: hw/fpwp_pkg.sv
// Register map, field layout and reset values of the flash page write protect block
package fpwp_pkg;
	localparam logic [7:0]  FPWP_PROT_OFFSET     = 8'h00;
	localparam logic [7:0]  FPWP_KEY_OFFSET      = 8'h04;
	localparam logic [7:0]  FPWP_STATUS_OFFSET   = 8'h08;
	localparam int          FPWP_UNLOCK_POS      = 31;
	localparam int          FPWP_BOUND_MSB       = 23;
	localparam int          FPWP_BOUND_WIDTH     = 24;
	localparam logic        FPWP_UNLOCK_RESET    = 1'b1;
	localparam logic [23:0] FPWP_BOUND_RESET     = 24'h000000;
	localparam logic [7:0]  FPWP_FLASH_PREFIX    = 8'h1D;
	localparam int          FPWP_PAGE_SHIFT      = 12;
	localparam logic [31:0] FPWP_KEY_FIRST       = 32'h5A5A_C3C3;
	localparam logic [31:0] FPWP_KEY_SECOND      = 32'hC3C3_5A5A;
	typedef enum logic [1:0] {FPWP_KEY_IDLE, FPWP_KEY_HALF, FPWP_KEY_ARMED} fpwp_key_state_type;
endpackage

// file: hw/fpwp_top.sv
// Flash page write protect register with lock, key gate and program address check
`timescale 1ns/100ps
module fpwp_top
	import fpwp_pkg::*;
#(
	parameter int          PAGE_SHIFT = fpwp_pkg::FPWP_PAGE_SHIFT,
	parameter logic [31:0] KEY_FIRST  = fpwp_pkg::FPWP_KEY_FIRST,
	parameter logic [31:0] KEY_SECOND = fpwp_pkg::FPWP_KEY_SECOND
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        chk_valid,
	input  wire logic [31:0] chk_addr,
	output logic             chk_done,
	output logic             chk_blocked
);
	import fpwp_pkg::*;

	logic                          page_protect_unlock;
	logic [FPWP_BOUND_WIDTH-1:0]   protect_boundary;
	logic                          key_armed;
	logic                          access;
	logic                          wr;
	logic                          hit_prot;
	logic                          hit_key;
	logic                          hit_status;
	logic                          mapped;
	logic                          prot_wr;
	logic                          prot_ok;
	logic                          last_refused;
	logic [31:0]                   prot_word;
	logic [31:0]                   next_prdata;
	logic                          next_blocked;

	assign access     = psel & penable;
	assign wr         = access & pwrite;
	assign hit_prot   = (paddr == FPWP_PROT_OFFSET);
	assign hit_key    = (paddr == FPWP_KEY_OFFSET);
	assign hit_status = (paddr == FPWP_STATUS_OFFSET);
	assign mapped     = hit_prot | hit_key | hit_status;
	assign pready     = 1'b1;
	assign pslverr    = access & ~mapped;
	assign prot_wr    = wr & hit_prot;
	assign prot_ok    = page_protect_unlock & key_armed;

	fpwp_key_seq #(
		.KEY_FIRST  (KEY_FIRST),
		.KEY_SECOND (KEY_SECOND)
	) u_key (
		.pclk     (pclk),
		.presetn  (presetn),
		.key_wr   (wr & hit_key & (pstrb == 4'hF)),
		.key_data (pwdata),
		.other_wr (wr & ~hit_key),
		.armed    (key_armed)
	);

	// Boundary field, byte lanes honoured
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			protect_boundary <= FPWP_BOUND_RESET;
		end else if (prot_wr && prot_ok) begin
			for (int b = 0; b < 3; b++) begin
				if (pstrb[b]) begin
					protect_boundary[b*8 +: 8] <= pwdata[b*8 +: 8];
				end
			end
		end
	end

	// Unlock can only go low here; only reset raises it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_protect_unlock <= FPWP_UNLOCK_RESET;
		end else if (prot_wr && prot_ok && pstrb[3] && !pwdata[FPWP_UNLOCK_POS]) begin
			page_protect_unlock <= 1'b0;
		end
	end

	// Sticky record of the last protect write outcome, for software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_refused <= 1'b0;
		end else if (prot_wr) begin
			last_refused <= ~prot_ok;
		end
	end

	assign prot_word = {page_protect_unlock, 7'h00, protect_boundary};

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_prot) begin
			next_prdata = prot_word;
		end else if (hit_status) begin
			next_prdata = {29'h0000_0000, last_refused, page_protect_unlock, key_armed};
		end
	end

	// Read data loaded in the setup cycle, shown in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// Page compare: with a nonzero boundary, same page as the boundary or any lower page is protected
	always_comb begin
		next_blocked = 1'b0;
		if (protect_boundary != FPWP_BOUND_RESET
			&& chk_addr[31:24] == FPWP_FLASH_PREFIX
			&& chk_addr[23:PAGE_SHIFT] <= protect_boundary[23:PAGE_SHIFT]) begin
			next_blocked = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_done    <= 1'b0;
			chk_blocked <= 1'b0;
		end else begin
			chk_done <= chk_valid;
			if (chk_valid) begin
				chk_blocked <= next_blocked;
			end
		end
	end

	property p_locked_write_refused;
		@(posedge pclk) disable iff (!presetn)
		(prot_wr && !page_protect_unlock) |=> $stable(protect_boundary);
	endproperty
	a_locked_write_refused: assert property (p_locked_write_refused)
		else $error("protect register changed while locked");

	property p_unlock_never_rises;
		@(posedge pclk) disable iff (!presetn)
		!page_protect_unlock |=> !page_protect_unlock;
	endproperty
	a_unlock_never_rises: assert property (p_unlock_never_rises)
		else $error("unlock bit set again without reset");

	property p_unimpl_zero;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_prot) |=> (prdata[30:24] == 7'h00);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero)
		else $error("unimplemented bits read nonzero");

	property p_below_blocked;
		@(posedge pclk) disable iff (!presetn)
		(chk_valid && protect_boundary != FPWP_BOUND_RESET
			&& chk_addr[31:24] == FPWP_FLASH_PREFIX
			&& chk_addr[23:0] < protect_boundary && $stable(protect_boundary))
			|=> (chk_done && chk_blocked);
	endproperty
	a_below_blocked: assert property (p_below_blocked)
		else $error("address below boundary not blocked");

	property p_zero_open;
		@(posedge pclk) disable iff (!presetn)
		(chk_valid && protect_boundary == 24'h0) |=> !chk_blocked;
	endproperty
	a_zero_open: assert property (p_zero_open)
		else $error("blocked with zero boundary");

	property p_same_page;
		@(posedge pclk) disable iff (!presetn)
		(chk_valid && protect_boundary != 24'h0 && chk_addr[31:24] == 8'h1D
			&& chk_addr[23:PAGE_SHIFT] == protect_boundary[23:PAGE_SHIFT]) |=> chk_blocked;
	endproperty
	a_same_page: assert property (p_same_page)
		else $error("boundary page not protected");

	property p_key_needed;
		@(posedge pclk) disable iff (!presetn)
		(prot_wr && !key_armed) |=> ($stable(protect_boundary) && $stable(page_protect_unlock));
	endproperty
	a_key_needed: assert property (p_key_needed)
		else $error("protect write took effect without key sequence");

	property p_refused_flag;
		@(posedge pclk) disable iff (!presetn)
		(prot_wr && !prot_ok) |=> (last_refused && $stable(page_protect_unlock));
	endproperty
	a_refused_flag: assert property (p_refused_flag)
		else $error("refused write altered state or was not flagged");

	property p_lane_write_lands;
		@(posedge pclk) disable iff (!presetn)
		(prot_wr && prot_ok && pstrb[0]) |=> (protect_boundary[7:0] == $past(pwdata[7:0]));
	endproperty
	a_lane_write_lands: assert property (p_lane_write_lands)
		else $error("accepted protect write did not land");

	property p_check_answered;
		@(posedge pclk) disable iff (!presetn)
		chk_valid |=> chk_done;
	endproperty
	a_check_answered: assert property (p_check_answered)
		else $error("address check not answered");

	c_unlock_cleared: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(page_protect_unlock));
	c_write_taken: cover property (@(posedge pclk) disable iff (!presetn)
		prot_wr && prot_ok ##1 protect_boundary != 24'h0);
	c_check_blocked: cover property (@(posedge pclk) disable iff (!presetn)
		chk_done && chk_blocked);
	c_locked_refusal: cover property (@(posedge pclk) disable iff (!presetn)
		prot_wr && key_armed && !page_protect_unlock);
	c_status_read: cover property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && hit_status);
endmodule

// file: testbench/test_flash_page_write_protect.sv
// Self-checking bench for the flash page write protect register
`timescale 1ns/100ps
module test_flash_page_write_protect;
	import fpwp_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        chk_valid = 1'b0;
	logic [31:0] chk_addr = 32'h0;
	logic        chk_done;
	logic        chk_blocked;
	logic [15:0] lfsr = 16'h8273;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          cyc = 0;
	logic [31:0] v;
	logic        e;
	logic [23:0] b;

	always #50 pclk = ~pclk;

	fpwp_top u_fpwp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chk_valid(chk_valid), .chk_addr(chk_addr),
		.chk_done(chk_done), .chk_blocked(chk_blocked));

	task automatic rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		v[31:16] = lfsr;
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		v[15:0] = lfsr;
	endtask

	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer with byte lanes; read data and error land in v and e
	task automatic apb_s(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && cyc < 5000);
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb_s(w, a, d, 4'hF);
	endtask

	task automatic key();
		apb(1'b1, FPWP_KEY_OFFSET, FPWP_KEY_FIRST);
		apb(1'b1, FPWP_KEY_OFFSET, FPWP_KEY_SECOND);
	endtask

	// Expected verdict worked out from boundary and page number
	function automatic logic exp_blocked(input logic [31:0] a, input logic [23:0] bnd);
		return bnd != 24'h0 && a[31:24] == FPWP_FLASH_PREFIX && a[23:12] <= bnd[23:12];
	endfunction

	task automatic chk(input logic [31:0] a, input logic [23:0] bnd);
		logic x;
		x = exp_blocked(a, bnd);
		@(posedge pclk);
		chk_valid <= 1'b1;
		chk_addr <= a;
		@(posedge pclk);
		chk_valid <= 1'b0;
		@(posedge pclk);
		cmp({30'h0, chk_done, chk_blocked}, {30'h0, 1'b1, x});
	endtask

	task automatic conclude();
		$display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
		cmp(v, 32'h8000_0000);
		apb(1'b1, FPWP_PROT_OFFSET, 32'h00AB_CDEF);
		apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
		cmp(v, 32'h8000_0000);
		apb(1'b0, 8'h10, 32'h0);
		cmp({31'h0, e}, 32'h1);
		$display("test reset and key gate done");
		for (int i = 0; i < 8; i++) begin
			rnd();
			b = (i == 0) ? 24'h0 : (i == 1) ? 24'hFFFFFF : v[23:0];
			key();
			apb(1'b1, FPWP_PROT_OFFSET, {8'hFF, b});
			apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
			cmp(v, {8'h80, b});
			rnd();
			chk({FPWP_FLASH_PREFIX, b[23:12], v[11:0]}, b);
			chk({FPWP_FLASH_PREFIX, b[23:12] + 12'h1, v[11:0]}, b);
			chk({FPWP_FLASH_PREFIX, 12'h000, v[23:12]}, b);
			chk(v, b);
		end
		$display("test random boundaries done");
		key();
		apb(1'b1, FPWP_PROT_OFFSET, 32'h0000_3123);
		apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
		cmp(v, 32'h0000_3123);
		key();
		apb(1'b1, FPWP_PROT_OFFSET, 32'hFFFF_FFFF);
		apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
		cmp(v, 32'h0000_3123);
		chk(32'h1D00_3FFF, 24'h003123);
		chk(32'h1D00_4000, 24'h003123);
		$display("test lock done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
		cmp(v, 32'h8000_0000);
		apb(1'b1, FPWP_KEY_OFFSET, FPWP_KEY_FIRST);
		apb_s(1'b1, FPWP_KEY_OFFSET, FPWP_KEY_SECOND, 4'h7);
		apb(1'b1, FPWP_PROT_OFFSET, 32'h0000_1111);
		apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
		cmp(v, 32'h8000_0000);
		apb(1'b0, FPWP_STATUS_OFFSET, 32'h0);
		cmp(v, 32'h0000_0006);
		key();
		apb_s(1'b1, FPWP_PROT_OFFSET, 32'h0012_3456, 4'h3);
		apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
		cmp(v, 32'h8000_3456);
		key();
		apb(1'b1, 8'h10, 32'h0);
		cmp({31'h0, e}, 32'h1);
		apb(1'b1, FPWP_PROT_OFFSET, 32'h0000_0000);
		apb(1'b0, FPWP_PROT_OFFSET, 32'h0);
		cmp(v, 32'h8000_3456);
		$display("test second reset done");
		conclude();
	end
endmodule
